// ==== design/pfm_packet_fifo.sv ====
// Purpose: 64 byte fifo, serial shifter and frame engine of the fsk path
// Assumes: bit_tick is one cycle per bit at the programmed bit rate
// Notes:   host fifo access is one byte per host_wr or host_rd pulse
//
// Notes on behaviour
// R1: continuous mode passes bits on the data pin; packet mode uses fifo
// R2: packet frames carry preamble, pattern, payload; payload capped 255/2047
// R3: fifo is one byte wide, whole byte accesses from the host only
// R4: fifo depth is sixty-four bytes
// R5: transmit shifter sends fifo bytes msb first at the bit rate
// R6: receive shifter gathers bits and writes each whole byte to fifo
// R7: host waits for mode settled flag before using fifo after sleep
// R8: vacant source high exactly when fifo holds no byte
// R9: vacant source updates at select falling edge; host rechecks it
// R10: filled source high exactly when all sixty-four bytes held
// R11: write into full fifo is dropped and flags overflow; clear empties
// R12: frame transmitted source rises after last bit of the frame
// R13: threshold source re-evaluated only on fifo read or write
// R14: threshold source frozen once full until fifo emptied
// R15: fifo kept across standby/sleep and on entering transmit
// R16: fifo kept when leaving receive for standby or sleep
// R17: fifo cleared entering receive, receive to transmit, leaving transmit
// R18: pattern recognition needs enable; continuous mode needs bit sync
// R19: incoming bits shift through comparator; full agreement sets flag
// R20: first bit meets pattern bit 63, last meets bit 0 of last byte
// R21: matched flag cleared on leaving receive or fifo becoming empty
// R22: pattern length one to eight bytes, also used for sent pattern
// R23: host never programs a zero byte into the pattern value
// R24: threshold source high when stored count exceeds threshold
`timescale 1ns/1ps
module pfm_packet_fifo
    import pfm_pkg::*;
#(
    parameter int DEPTH    = FIFO_DEPTH,
    parameter int PRE_LEN  = PREAMBLE_BYTES
)(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    input  wire logic [1:0]           chip_mode,
    input  wire logic                 packet_mode,
    input  wire logic                 spi_select_n,
    input  wire logic                 host_wr,
    input  wire logic [BYTE_W-1:0]    host_wdata,
    input  wire logic                 host_rd,
    output logic [BYTE_W-1:0]         host_rdata,
    input  wire logic                 overflow_clear,
    input  wire logic [PTR_W-1:0]     fill_trigger_count,
    input  wire logic [10:0]          payload_length,
    input  wire logic                 long_length,
    input  wire logic                 unlimited_length,
    input  wire logic                 pattern_match_enable,
    input  wire logic                 bit_sync_enable,
    input  wire logic [2:0]           pattern_length_field,
    input  wire logic [PATTERN_W-1:0] pattern_value_field,
    input  wire logic                 bit_tick,
    input  wire logic                 demod_bit,
    output logic                      mod_bit,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    output logic                      serial_data_oe_n,
    output logic                      fifo_vacant_src,
    output logic                      fifo_filled_src,
    output logic                      fifo_overflow_flag,
    output logic                      frame_transmitted_src,
    output logic                      fill_trigger_src,
    output logic                      mode_settled_flag,
    output logic                      pattern_matched_flag
);

    typedef struct packed {
        logic [DEPTH-1:0][BYTE_W-1:0] mem;
        logic [PTR_W-1:0]  wptr;
        logic [PTR_W-1:0]  rptr;
        logic [CNT_W-1:0]  cnt;
        logic [BYTE_W-1:0] rdata;
        logic              vacant;
        logic              filled;
        logic              ovf;
        logic              trig;
        logic              trig_frozen;
        logic              sent;
        logic              settled;
        logic [1:0]        prev_mode;
        logic              prev_sel_n;
        pfm_eng_t          eng;
        logic [BYTE_W-1:0] sh;
        logic [2:0]        bits_left;
        logic [10:0]       byte_idx;
        logic              mod_bit;
        logic              sdo;
        logic              sdo_oe_n;
    } pfm_state_t;

    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [10:0]      PRE_LAST = 11'(PRE_LEN - 1);

    pfm_state_t        s_r;
    pfm_state_t        s_nxt;
    logic              mode_chg;
    logic              in_tx;
    logic              in_rx;
    logic              flush;
    logic [10:0]       len_cap;
    logic [10:0]       len_eff;
    logic              sr_rd;
    logic              sr_wr;
    logic [BYTE_W-1:0] sr_wdata;
    logic [BYTE_W-1:0] fetch;
    logic              fetch_go;
    logic              tx_done;
    logic              host_w;
    logic              host_r;
    logic              wr_req;
    logic              wr_ok;
    logic              rd_ok;
    logic              ovf_evt;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              match_en;
    logic              match_bit;
    logic              match_clr;
    logic              sync_hit;

    function automatic logic [7:0] pfm_sync_byte(
        input logic [PATTERN_W-1:0] v,
        input logic [2:0]           k
    );
        logic [5:0] top;
        top = 6'd63 - {k, 3'b000};
        pfm_sync_byte = v[top -: 8];
    endfunction : pfm_sync_byte

    // ==========================================================
    // next state
    always_comb begin
        s_nxt    = s_r;
        in_tx    = (chip_mode == MODE_TX);
        in_rx    = (chip_mode == MODE_RX);
        mode_chg = (chip_mode != s_r.prev_mode);
        // transmit exit, receive entry and rx to tx empty the fifo
        flush    = overflow_clear | (mode_chg &                      // R11
                   ((s_r.prev_mode == MODE_TX) || in_rx ||           // R17
                    ((s_r.prev_mode == MODE_RX) && in_tx)));         // R15 R16
        len_cap  = long_length ? PAY_MAX_LONG : PAY_MAX_SHORT;       // R2
        len_eff  = (payload_length > len_cap) ? len_cap : payload_length;
        sr_rd    = 1'b0;
        sr_wr    = 1'b0;
        sr_wdata = 8'h00;
        fetch    = 8'h00;
        fetch_go = 1'b0;
        tx_done  = 1'b0;

        // frame engine
        case (s_r.eng)
            ENG_IDLE: begin
                if (packet_mode && in_tx && !s_r.sent) begin         // R1
                    s_nxt.eng      = ENG_PRE;
                    s_nxt.byte_idx = 11'h000;
                    s_nxt.bits_left = 3'h0;
                end else if (packet_mode && in_rx && sync_hit) begin
                    s_nxt.eng       = ENG_RXPAY;
                    s_nxt.byte_idx  = 11'h000;
                    s_nxt.bits_left = 3'h0;
                end
            end
            ENG_PRE, ENG_SYNC, ENG_PAY: begin
                if (bit_tick && s_r.bits_left != 3'h0) begin
                    s_nxt.mod_bit   = s_r.sh[7];                     // R5
                    s_nxt.sh        = {s_r.sh[6:0], 1'b0};
                    s_nxt.bits_left = s_r.bits_left - 3'h1;
                end else if (bit_tick && s_r.eng == ENG_PRE) begin
                    fetch          = PREAMBLE_BYTE;                  // R2
                    fetch_go       = 1'b1;
                    s_nxt.byte_idx = s_r.byte_idx + 11'h001;
                    if (s_r.byte_idx == PRE_LAST) begin
                        s_nxt.eng      = ENG_SYNC;
                        s_nxt.byte_idx = 11'h000;
                    end
                end else if (bit_tick && s_r.eng == ENG_SYNC) begin
                    fetch    = pfm_sync_byte(pattern_value_field,
                                             s_r.byte_idx[2:0]);     // R22
                    fetch_go = 1'b1;
                    s_nxt.byte_idx = s_r.byte_idx + 11'h001;
                    if (s_r.byte_idx[2:0] == pattern_length_field) begin
                        s_nxt.eng      = ENG_PAY;
                        s_nxt.byte_idx = 11'h000;
                    end
                end else if (bit_tick) begin
                    if (unlimited_length ? (s_r.cnt == 7'h00)
                                         : (s_r.byte_idx == len_eff)) begin
                        tx_done   = 1'b1;                            // R12
                        s_nxt.eng = ENG_END;
                    end else if (s_r.cnt != 7'h00) begin
                        fetch    = s_r.mem[s_r.rptr];                // R5
                        fetch_go = 1'b1;
                        sr_rd    = 1'b1;
                        s_nxt.byte_idx = s_r.byte_idx + 11'h001;
                    end
                end
                if (fetch_go) begin
                    s_nxt.mod_bit   = fetch[7];                      // R5
                    s_nxt.sh        = {fetch[6:0], 1'b0};
                    s_nxt.bits_left = 3'h7;
                end
            end
            ENG_RXPAY: begin
                if (bit_tick) begin
                    s_nxt.sh        = {s_r.sh[6:0], demod_bit};      // R6
                    s_nxt.bits_left = s_r.bits_left + 3'h1;
                    if (s_r.bits_left == 3'h7) begin
                        sr_wr          = 1'b1;                       // R6
                        sr_wdata       = {s_r.sh[6:0], demod_bit};
                        s_nxt.byte_idx = s_r.byte_idx + 11'h001;
                        if (!unlimited_length &&
                            (s_r.byte_idx + 11'h001 >= len_eff)) begin
                            s_nxt.eng = ENG_END;                     // R2
                        end
                    end
                end
            end
            ENG_END: begin
                s_nxt.eng = ENG_END;
            end
            default: begin
                s_nxt.eng = ENG_IDLE;
            end
        endcase
        if (mode_chg) begin
            s_nxt.eng       = ENG_IDLE;
            s_nxt.bits_left = 3'h0;
            s_nxt.byte_idx  = 11'h000;
        end

        // continuous mode: bits bypass the fifo
        if (!packet_mode && in_tx && bit_tick) begin
            s_nxt.mod_bit = serial_data_in;                          // R1
        end
        if (!packet_mode && in_rx && bit_tick) begin
            s_nxt.sdo = demod_bit;                                   // R1
        end
        s_nxt.sdo_oe_n = ~(!packet_mode && in_rx);

        // fifo
        host_w  = host_wr & ~in_rx;                                  // R3
        host_r  = host_rd & ~in_tx;
        wr_req  = host_w | sr_wr;
        ovf_evt = wr_req & (s_r.cnt == FULL_CNT);                    // R11
        wr_ok   = wr_req & (s_r.cnt != FULL_CNT);
        rd_ok   = (host_r | sr_rd) & (s_r.cnt != 7'h00);
        cnt_nxt = s_r.cnt + CNT_W'(wr_ok) - CNT_W'(rd_ok);
        if (flush) begin
            cnt_nxt     = 7'h00;
            s_nxt.wptr  = 6'h00;
            s_nxt.rptr  = 6'h00;
        end else begin
            if (wr_ok) begin
                s_nxt.mem[s_r.wptr] = sr_wr ? sr_wdata : host_wdata; // R4
                s_nxt.wptr          = s_r.wptr + 6'h01;
            end
            if (rd_ok) begin
                s_nxt.rptr = s_r.rptr + 6'h01;
                if (host_r && !sr_rd) begin
                    s_nxt.rdata = s_r.mem[s_r.rptr];                 // R3
                end
            end
        end
        s_nxt.cnt = cnt_nxt;

        // status sources
        s_nxt.ovf    = ovf_evt | (s_r.ovf & ~overflow_clear);        // R11
        s_nxt.filled = (cnt_nxt == FULL_CNT);                        // R10
        if (!spi_select_n && s_r.prev_sel_n) begin
            s_nxt.vacant = (cnt_nxt == 7'h00);                       // R9
        end else if (spi_select_n) begin
            s_nxt.vacant = (cnt_nxt == 7'h00);                       // R8
        end
        if (cnt_nxt == FULL_CNT) begin
            s_nxt.trig_frozen = 1'b1;                                // R14
        end else if (cnt_nxt == 7'h00) begin
            s_nxt.trig_frozen = 1'b0;
        end
        if ((wr_ok || rd_ok) && !s_nxt.trig_frozen) begin            // R13
            s_nxt.trig = (cnt_nxt > {1'b0, fill_trigger_count});     // R24
        end
        s_nxt.sent       = tx_done | (s_r.sent & ~mode_chg);         // R12
        s_nxt.settled    = ~mode_chg;
        s_nxt.prev_mode  = chip_mode;
        s_nxt.prev_sel_n = spi_select_n;

        // pattern recognition feed
        match_en  = pattern_match_enable & (packet_mode | bit_sync_enable);
        match_bit = bit_tick & in_rx & (s_r.eng == ENG_IDLE);
        match_clr = ~in_rx | ((s_r.cnt != 7'h00) && (cnt_nxt == 7'h00));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r            <= '0;
            s_r.vacant     <= RST_VACANT;
            s_r.settled    <= RST_SETTLED;
            s_r.sdo_oe_n   <= RST_OE_N;
            s_r.prev_sel_n <= 1'b1;
            s_r.eng        <= ENG_IDLE;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // pattern recognizer
    pfm_sync_match u_match (
        .clk     (clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .enable  (match_en),                                         // R18
        .bit_valid (match_bit),
        .bit_in  (demod_bit),
        .length  (pattern_length_field),                             // R22
        .value   (pattern_value_field),
        .clear   (match_clr),                                        // R21
        .matched (pattern_matched_flag),
        .hit     (sync_hit)
    );

    assign host_rdata            = s_r.rdata;
    assign mod_bit               = s_r.mod_bit;
    assign serial_data_out       = s_r.sdo;
    assign serial_data_oe_n      = s_r.sdo_oe_n;
    assign fifo_vacant_src       = s_r.vacant;
    assign fifo_filled_src       = s_r.filled;
    assign fifo_overflow_flag    = s_r.ovf;
    assign frame_transmitted_src = s_r.sent;
    assign fill_trigger_src      = s_r.trig;
    assign mode_settled_flag     = s_r.settled;

    // ==========================================================
    // checks
    default clocking pfm_cb @(posedge clk iff clk_en); endclocking
    default disable iff (!arst_n);

    a_filled_level: assert property ( // R10
        fifo_filled_src == (s_r.cnt == FULL_CNT))
        else $error("filled source disagrees with fill count");
    a_vacant_idle: assert property ( // R8
        $past(spi_select_n) |-> fifo_vacant_src == (s_r.cnt == 7'h00))
        else $error("vacant source wrong outside transaction");
    a_vacant_hold: assert property ( // R9
        $past(!spi_select_n) && $past(!spi_select_n, 2)
        |-> $stable(fifo_vacant_src))
        else $error("vacant source moved inside transaction");
    a_ovf_drop: assert property ( // R11
        host_wr && chip_mode == MODE_STDBY && !mode_chg && !overflow_clear
        && s_r.cnt == FULL_CNT && !host_rd
        |=> fifo_overflow_flag && s_r.cnt == FULL_CNT)
        else $error("write into full fifo not flagged");
    a_ovf_clear: assert property ( // R11
        overflow_clear |=> s_r.cnt == 7'h00)
        else $error("overflow clear left bytes in fifo");
    a_trig_static: assert property ( // R13
        !(wr_ok || rd_ok) |=> $stable(fill_trigger_src))
        else $error("threshold source moved without access");
    a_tx_exit_clear: assert property ( // R17
        mode_chg && s_r.prev_mode == MODE_TX |=> s_r.cnt == 7'h00)
        else $error("fifo kept after leaving transmit");
    a_preload_kept: assert property ( // R15
        mode_chg && in_tx && s_r.prev_mode == MODE_STDBY && !host_wr
        && !overflow_clear |=> s_r.cnt == $past(s_r.cnt))
        else $error("preloaded fifo lost entering transmit");
    a_msb_first: assert property ( // R5
        bit_tick && !mode_chg && s_r.eng == ENG_PAY && s_r.bits_left != 3'h0
        |=> mod_bit == $past(s_r.sh[7]))
        else $error("payload bit order wrong");
    a_sent_cause: assert property ( // R12
        $rose(frame_transmitted_src) |-> $past(s_r.eng) == ENG_PAY)
        else $error("frame transmitted without payload end");

    c_overflow: cover property ($rose(fifo_overflow_flag));
    c_sent:     cover property ($rose(frame_transmitted_src));
    c_match:    cover property ($rose(pattern_matched_flag));
    c_trig:     cover property ($rose(fill_trigger_src));

endmodule : pfm_packet_fifo

// ==== design/pfm_pkg.sv ====
// Purpose: shared constants and types of the packet fifo and pattern match
// Assumes: one 40 MHz clock, byte wide fifo
// Notes:   chip mode codes are the encoding of the chip_mode input
package pfm_pkg;

    // ==========================================================
    // fifo geometry
    localparam int          FIFO_DEPTH = 64;
    localparam int          PTR_W      = 6;
    localparam int          CNT_W      = 7;
    localparam int          BYTE_W     = 8;

    // ==========================================================
    // chip modes
    localparam logic [1:0]  MODE_SLEEP = 2'h0;
    localparam logic [1:0]  MODE_STDBY = 2'h1;
    localparam logic [1:0]  MODE_TX    = 2'h2;
    localparam logic [1:0]  MODE_RX    = 2'h3;

    // ==========================================================
    // frame layout
    localparam logic [10:0] PAY_MAX_SHORT  = 11'h0ff;
    localparam logic [10:0] PAY_MAX_LONG   = 11'h7ff;
    localparam logic [7:0]  PREAMBLE_BYTE  = 8'haa;
    localparam int          PREAMBLE_BYTES = 3;
    localparam int          PATTERN_W      = 64;

    // ==========================================================
    // reset values
    localparam logic        RST_VACANT  = 1'b1;
    localparam logic        RST_SETTLED = 1'b1;
    localparam logic        RST_OE_N    = 1'b1;

    // ==========================================================
    // frame engine states
    typedef enum logic [5:0] {
        ENG_IDLE  = 6'h01,
        ENG_PRE   = 6'h02,
        ENG_SYNC  = 6'h04,
        ENG_PAY   = 6'h08,
        ENG_RXPAY = 6'h10,
        ENG_END   = 6'h20
    } pfm_eng_t;

endpackage : pfm_pkg

// ==== design/pfm_sync_match.sv ====
// Purpose: sliding comparator of received bits against the pattern value
// Assumes: bit_valid marks one demodulated bit per pulse
// Notes:   matched flag is sticky until clear; a new hit beats the clear
`timescale 1ns/1ps
module pfm_sync_match
    import pfm_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    input  wire logic                 enable,
    input  wire logic                 bit_valid,
    input  wire logic                 bit_in,
    input  wire logic [2:0]           length,
    input  wire logic [PATTERN_W-1:0] value,
    input  wire logic                 clear,
    output logic                      matched,
    output logic                      hit
);

    typedef struct packed {
        logic [PATTERN_W-1:0] hist;
        logic                 fresh;
        logic                 matched;
        logic                 hit;
    } pfm_match_st_t;

    pfm_match_st_t        s_r;
    pfm_match_st_t        s_nxt;
    logic [6:0]           nbits;
    logic [6:0]           shamt;
    logic [PATTERN_W-1:0] mask;
    logic                 hit_now;

    // ==========================================================
    // compare
    always_comb begin
        s_nxt   = s_r;
        nbits   = 7'({length, 3'b000}) + 7'd8;
        shamt   = 7'd64 - nbits;
        mask    = {PATTERN_W{1'b1}} >> shamt;
        // oldest bit against value[63], newest against bit 0 of last byte
        hit_now = enable && s_r.fresh &&
                  (((s_r.hist ^ (value >> shamt)) & mask) == 64'h0); // R19 R20
        // zero history never matches a pattern free of zero bytes; R23
        s_nxt.fresh = 1'b0;
        if (!enable) begin
            s_nxt.hist = 64'h0; // R18
        end else if (bit_valid) begin
            s_nxt.hist  = {s_r.hist[PATTERN_W-2:0], bit_in}; // R19
            s_nxt.fresh = 1'b1;
        end
        s_nxt.hit     = hit_now;
        s_nxt.matched = hit_now | (s_r.matched & ~clear); // R21
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign matched = s_r.matched;
    assign hit     = s_r.hit;

    // ==========================================================
    // checks
    a_hit_needs_en: assert property (@(posedge clk iff clk_en) // R18
        disable iff (!arst_n) hit |-> $past(enable))
        else $error("pattern hit while recognition disabled");
    a_hit_sets_flag: assert property (@(posedge clk iff clk_en) // R19
        disable iff (!arst_n) hit |-> matched)
        else $error("pattern hit did not set matched flag");
    a_clear_flag: assert property (@(posedge clk iff clk_en) // R21
        disable iff (!arst_n) clear && !hit_now |=> !matched)
        else $error("matched flag survived clear");

endmodule : pfm_sync_match

// ==== tb/pfm_host_model.sv ====
// Purpose: host side model driving the fifo access strobes
// Assumes: strobes change on the falling clock edge only
// Notes:   one byte per call; data lines show garbage when idle
`timescale 1ns/1ps
module pfm_host_model
    import pfm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              settled,
    output logic                   wr,
    output logic                   rd,
    output logic [BYTE_W-1:0]      wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end
    // single write (w=1) or read (w=0) strobe of one cycle
    task automatic xfer(input logic w, input logic [BYTE_W-1:0] d);
        @(negedge clk);
        while (settled !== 1'b1) @(negedge clk);
        wr = w;
        rd = !w;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        wdata = ~d;
    endtask : xfer
endmodule : pfm_host_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the packet fifo
// Assumes: spi select high except during one read, where vacant holds; else vacant tracks every cycle
// Notes:   random bytes and threshold from a fixed seed
`timescale 1ns/1ps
module testbench;
    import pfm_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, packet_mode = 1'b1;
    logic [1:0] chip_mode = MODE_SLEEP;
    logic spi_select_n = 1'b1, overflow_clear = 1'b0, bit_tick = 1'b0;
    logic demod_bit = 1'b0, serial_data_in = 1'b0, long_length = 1'b0;
    logic unlimited_length = 1'b0, pattern_match_enable = 1'b1;
    logic bit_sync_enable = 1'b1;
    logic [2:0] pattern_length_field = 3'h3;
    logic [PATTERN_W-1:0] pattern_value_field = 64'h0102030405060708;
    logic [PTR_W-1:0] fill_trigger_count = '0;
    logic [10:0] payload_length = 11'h004;
    logic host_wr, host_rd, fifo_vacant_src, fifo_filled_src;
    logic fifo_overflow_flag, fill_trigger_src, mode_settled_flag;
    logic [BYTE_W-1:0] host_wdata, host_rdata, d;
    logic [BYTE_W-1:0] q[$];
    logic mod_bit, serial_data_out, serial_data_oe_n, frame_transmitted_src;
    logic pattern_matched_flag;
    logic [31:0] pay;
    logic [87:0] fr;
    int mismatches = 0, n_tests = 0, cyc = 0;
    always #12.5 clk = ~clk;
    pfm_host_model i_host (.clk(clk), .settled(mode_settled_flag),
        .wr(host_wr), .rd(host_rd), .wdata(host_wdata));
    pfm_packet_fifo i_dut (.clk, .arst_n, .clk_en, .chip_mode, .packet_mode,
        .spi_select_n, .host_wr, .host_wdata, .host_rd, .host_rdata,
        .overflow_clear, .fill_trigger_count, .payload_length, .long_length,
        .unlimited_length, .pattern_match_enable, .bit_sync_enable,
        .pattern_length_field, .pattern_value_field, .bit_tick, .demod_bit,
        .mod_bit, .serial_data_in, .serial_data_out,
        .serial_data_oe_n, .fifo_vacant_src, .fifo_filled_src,
        .fifo_overflow_flag, .frame_transmitted_src, .fill_trigger_src,
        .mode_settled_flag, .pattern_matched_flag);
    function automatic logic exp_trig(input int c, input int t);
        return c > t;
    endfunction : exp_trig
    // one bit period: pulse for one cycle, then three idle cycles
    task automatic tick(input logic b);
        bit_tick = 1'b1;
        demod_bit = b;
        @(negedge clk);
        bit_tick = 1'b0;
        repeat (3) @(negedge clk);
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'h11ce));
        fill_trigger_count = 6'($urandom_range(0, 62));
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        chk(fifo_vacant_src, 1'b1);
        chip_mode = MODE_STDBY;
        repeat (2) @(negedge clk);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            d = 8'($urandom_range(1, 255));
            q.push_back(d);
            i_host.xfer(1'b1, d);
            if (i == 0) chk(fill_trigger_src, exp_trig(1, fill_trigger_count));
            if (i == 0) chk(fifo_vacant_src, 1'b0);
            chk(fifo_filled_src, i == FIFO_DEPTH - 1);
        end
        i_host.xfer(1'b1, 8'h5a);
        @(negedge clk);
        chk(fifo_overflow_flag, 1'b1);
        chip_mode = MODE_SLEEP;
        @(negedge clk);
        chk(mode_settled_flag, 1'b0);
        repeat (2) @(negedge clk);
        chip_mode = MODE_STDBY;
        repeat (2) @(negedge clk);
        chk(fifo_filled_src, 1'b1);
        while (q.size() > 0) begin
            i_host.xfer(1'b0, 8'h00);
            chk(host_rdata, q.pop_front());
            chk(fifo_vacant_src, q.size() == 0);
            chk(fill_trigger_src, q.size() != 0);
        end
        i_host.xfer(1'b1, 8'h3c);
        d = {2'b00, fill_trigger_count};
        fill_trigger_count = (d == 8'h00) ? 6'h3f : 6'h00;
        repeat (2) @(negedge clk);
        chk(fill_trigger_src, exp_trig(1, d));
        overflow_clear = 1'b1;
        @(negedge clk);
        overflow_clear = 1'b0;
        @(negedge clk);
        chk(fifo_overflow_flag, 1'b0);
        chk(fifo_vacant_src, 1'b1);
        i_host.xfer(1'b1, 8'hc3);
        spi_select_n = 1'b0;
        i_host.xfer(1'b0, 8'h00);
        chk(host_rdata, 8'hc3);
        chk(fifo_vacant_src, 1'b0);
        spi_select_n = 1'b1;
        i_host.xfer(1'b1, 8'hc3);
        chip_mode = MODE_RX;
        repeat (3) @(negedge clk);
        chk(fifo_vacant_src, 1'b1);
        for (int i = 31; i >= 0; i--) tick(pattern_value_field[32+i]);
        chk(pattern_matched_flag, 1'b1);
        pay = $urandom();
        for (int i = 31; i >= 0; i--) tick(pay[i]);
        chip_mode = MODE_STDBY;
        repeat (2) @(negedge clk);
        chk(pattern_matched_flag, 1'b0);
        for (int i = 3; i >= 0; i--) begin
            i_host.xfer(1'b0, 8'h00);
            chk(host_rdata, pay[8*i +: 8]);
        end
        pay = $urandom();
        for (int i = 3; i >= 0; i--) i_host.xfer(1'b1, pay[8*i +: 8]);
        fr = {{PREAMBLE_BYTES{PREAMBLE_BYTE}},
              pattern_value_field[63:32], pay};
        chip_mode = MODE_TX;
        repeat (2) @(negedge clk);
        for (int i = 87; i >= 0; i--) begin
            tick(1'b0);
            chk(mod_bit, fr[i]);
        end
        chk(frame_transmitted_src, 1'b0);
        tick(1'b0);
        chk(frame_transmitted_src, 1'b1);
        packet_mode = 1'b0;
        chip_mode = MODE_RX;
        d = 8'($urandom());
        for (int i = 7; i >= 0; i--) begin
            tick(d[i]);
            chk(serial_data_out, d[i]);
        end
        chk(serial_data_oe_n, 1'b0);
        stop_test();
    end
endmodule : testbench
